// >>> src/fps_top.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
// Notes on behaviour
// - Pin-function bit clear: pin A is sync
// - Sync active during flash forces torch level
// - Sync released before timeout restores flash level
// - Timeout ends pulse regardless of sync
// - Polarity bit set high-active, clear low-active
// - Hardware enable low forces shutdown, any state
// - Trigger pin edge starts a flash
// - Two independent sync inputs interrupt flash
// - Eight host-readable flag bits
// - Host sets currents, timeout, limit; reads ADC
// - Four-bit LED voltage result readable
// - Timeout divided from 2 MHz switching clock
// - Pin-function bit set: pin A torch enable
module fps_top #(
    parameter int STEP_TICKS = fps_pkg::STEP_TICKS
) (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    input  wire logic               flash_trigger_pin,
    input  wire logic               multifunction_pin_a,
    input  wire logic               pa_sync_in_b,
    input  wire logic               hw_chip_enable,
    input  wire fps_pkg::fps_fault_t fault_pins,
    input  wire logic [3:0]         vled_code,
    output fps_pkg::fps_drive_t     drive,
    output logic [1:0]              current_limit,
    output logic                    flash_active,
    output logic                    irq
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 13;

    logic [NPIN-1:0] pins_raw;
    logic [NPIN-1:0] pins_s;
    logic            trig_s;
    logic            pin_a_s;
    logic            pin_b_s;
    logic            hw_chip_enable_s;
    fps_pkg::fps_fault_t fault_s;
    logic [3:0]      vled_s;

    assign pins_raw = {vled_code, fault_pins, hw_chip_enable,
                       pa_sync_in_b, multifunction_pin_a,
                       flash_trigger_pin};

    fps_sync2 #(
        .W (NPIN)
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .d     (pins_raw),
        .q     (pins_s)
    );

    assign trig_s  = pins_s[0];
    assign pin_a_s = pins_s[1];
    assign pin_b_s = pins_s[2];
    assign hw_chip_enable_s  = pins_s[3];
    assign fault_s = pins_s[8:4];
    assign vled_s  = pins_s[12:9];

    // Shutdown while the enable pin is low
    logic shdn;
    assign shdn = !hw_chip_enable_s;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] enable_reg;
    logic [7:0] config1;
    logic [7:0] torch_reg;
    logic [7:0] flash_reg;
    logic [7:0] dur_reg;
    logic [7:0] indic_reg;
    logic [7:0] flags;
    logic [7:0] irq_status;
    logic [7:0] irq_enable;
    logic [3:0] adc_result;

    logic wr_en;
    logic wr_cfg;
    logic wr_torch;
    logic wr_flash;
    logic wr_dur;
    logic wr_indic;
    logic wr_iclr;
    logic wr_ien;
    logic rd_flags;

    assign wr_en    = reg_wr && reg_addr == fps_pkg::ADDR_ENABLE;
    assign wr_cfg   = reg_wr && reg_addr == fps_pkg::ADDR_CONFIG1;
    assign wr_torch = reg_wr && reg_addr == fps_pkg::ADDR_TORCH;
    assign wr_flash = reg_wr && reg_addr == fps_pkg::ADDR_FLASH;
    assign wr_dur   = reg_wr && reg_addr == fps_pkg::ADDR_DUR;
    assign wr_indic = reg_wr && reg_addr == fps_pkg::ADDR_INDIC;
    assign wr_iclr  = reg_wr && reg_addr == fps_pkg::ADDR_IRQ_CLR;
    assign wr_ien   = reg_wr && reg_addr == fps_pkg::ADDR_IRQ_EN;
    assign rd_flags = reg_rd && reg_addr == fps_pkg::ADDR_FLAGS;

    logic [1:0] mode;
    logic       src_a_on;
    logic       src_b_on;
    logic       pin_func;
    logic       pol_a;
    logic       pol_b;

    assign mode     = enable_reg[fps_pkg::EN_MODE_LSB +: 2];
    assign src_a_on = enable_reg[fps_pkg::EN_SRC_A];
    assign src_b_on = enable_reg[fps_pkg::EN_SRC_B];
    assign pin_func = config1[fps_pkg::CFG_PINFUNC];
    assign pol_a    = config1[fps_pkg::CFG_POL_A];
    assign pol_b    = config1[fps_pkg::CFG_POL_B];

    // ------------------------------------------------------------
    // Sync and trigger decode
    // ------------------------------------------------------------
    logic sync_a;
    logic sync_b;
    logic forced;
    logic trig_d;
    logic trig_rise;
    logic any_src;
    logic hw_torch;
    logic start_flash;
    logic torch_req;
    logic timeout;
    logic hard_fault;

    assign sync_a     = !pin_func && (pin_a_s == pol_a);
    assign sync_b     = (pin_b_s == pol_b);
    assign forced     = sync_a || sync_b;
    assign hw_torch   = pin_func && pin_a_s;
    assign trig_rise  = trig_s && !trig_d;
    assign any_src    = src_a_on || src_b_on;
    assign start_flash = any_src && (trig_rise || mode == fps_pkg::MODE_FLASH);
    assign torch_req  = any_src && (hw_torch || mode == fps_pkg::MODE_TORCH);
    assign hard_fault = fault_s.thermal_sd || fault_s.led_fault;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_d <= 1'b0;
        end else begin
            trig_d <= trig_s;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    fps_pkg::fps_state_t state;
    fps_pkg::fps_state_t next_state;
    logic                in_flash;

    assign in_flash = (state == fps_pkg::ST_FLASH) || (state == fps_pkg::ST_FORCED);

    always_comb begin
        next_state = state;
        unique case (state)
            fps_pkg::ST_OFF, fps_pkg::ST_TORCH: begin
                if (start_flash && !hard_fault) begin
                    next_state = fps_pkg::ST_FLASH;
                end else if (torch_req) begin
                    next_state = fps_pkg::ST_TORCH;
                end else begin
                    next_state = fps_pkg::ST_OFF;
                end
            end
            fps_pkg::ST_FLASH: begin
                if (timeout || hard_fault) begin
                    next_state = fps_pkg::ST_OFF;
                end else if (forced) begin
                    next_state = fps_pkg::ST_FORCED;
                end
            end
            fps_pkg::ST_FORCED: begin
                if (timeout || hard_fault) begin
                    next_state = fps_pkg::ST_OFF;
                end else if (!forced) begin
                    next_state = fps_pkg::ST_FLASH;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= fps_pkg::ST_OFF;
        end else if (shdn) begin
            state <= fps_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    fps_timer #(
        .DIV   (fps_pkg::SW_DIV),
        .STEPS (STEP_TICKS)
    ) u_timer (
        .clock   (clock),
        .rst     (rst),
        .run     (in_flash && !shdn),
        .code    (dur_reg[4:0]),
        .expired (timeout)
    );

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_reg <= fps_pkg::RST_ENABLE;
        end else if (shdn) begin
            enable_reg <= fps_pkg::RST_ENABLE;
        end else if (wr_en) begin
            enable_reg <= reg_wdata;
        end else if (in_flash && next_state == fps_pkg::ST_OFF) begin
            enable_reg[fps_pkg::EN_MODE_LSB +: 2] <= fps_pkg::MODE_OFF;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            config1 <= fps_pkg::RST_CONFIG1;
        end else if (shdn) begin
            config1 <= fps_pkg::RST_CONFIG1;
        end else if (wr_cfg) begin
            config1 <= reg_wdata;
        end else if (in_flash && next_state == fps_pkg::ST_OFF) begin
            config1[fps_pkg::CFG_PINFUNC] <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            torch_reg <= fps_pkg::RST_TORCH;
            flash_reg <= fps_pkg::RST_FLASH;
            dur_reg   <= fps_pkg::RST_DUR;
            indic_reg <= fps_pkg::RST_INDIC;
        end else if (shdn) begin
            torch_reg <= fps_pkg::RST_TORCH;
            flash_reg <= fps_pkg::RST_FLASH;
            dur_reg   <= fps_pkg::RST_DUR;
            indic_reg <= fps_pkg::RST_INDIC;
        end else begin
            if (wr_torch) begin
                torch_reg <= reg_wdata;
            end
            if (wr_flash) begin
                flash_reg <= reg_wdata;
            end
            if (wr_dur) begin
                dur_reg <= reg_wdata;
            end
            if (wr_indic) begin
                indic_reg <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Flags, LED voltage result, interrupt
    // ------------------------------------------------------------
    logic [7:0] flag_set;

    always_comb begin
        flag_set                       = '0;
        flag_set[fps_pkg::FLG_TIMEOUT] = timeout && in_flash;
        flag_set[fps_pkg::FLG_LED_OT]  = fault_s.led_overtemp;
        flag_set[fps_pkg::FLG_LED_FLT] = fault_s.led_fault;
        flag_set[fps_pkg::FLG_TSD]     = fault_s.thermal_sd;
        flag_set[fps_pkg::FLG_VIN_UV]  = fault_s.vin_uv;
        flag_set[fps_pkg::FLG_VIN_FUV] = fault_s.vin_flash_uv;
        flag_set[fps_pkg::FLG_SYNC_A]  = in_flash && sync_a;
        flag_set[fps_pkg::FLG_SYNC_B]  = in_flash && sync_b;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else if (shdn) begin
            flags <= '0;
        end else if (rd_flags) begin
            flags <= flag_set;
        end else begin
            flags <= flags | flag_set;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
        end else if (shdn) begin
            irq_status <= '0;
        end else if (wr_iclr) begin
            irq_status <= (irq_status & ~reg_wdata) | flag_set;
        end else begin
            irq_status <= irq_status | flag_set;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_enable <= '0;
        end else if (wr_ien) begin
            irq_enable <= reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // Sample only while the flash current flows
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adc_result <= '0;
        end else if (shdn) begin
            adc_result <= '0;
        end else if (state == fps_pkg::ST_FLASH) begin
            adc_result <= vled_s;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                fps_pkg::ADDR_ENABLE:  reg_rdata <= enable_reg;
                fps_pkg::ADDR_CONFIG1: reg_rdata <= config1;
                fps_pkg::ADDR_TORCH:   reg_rdata <= torch_reg;
                fps_pkg::ADDR_FLASH:   reg_rdata <= flash_reg;
                fps_pkg::ADDR_DUR:     reg_rdata <= dur_reg;
                fps_pkg::ADDR_FLAGS:   reg_rdata <= flags;
                fps_pkg::ADDR_ADC:     reg_rdata <= {4'h0, adc_result};
                fps_pkg::ADDR_INDIC:   reg_rdata <= indic_reg;
                fps_pkg::ADDR_IRQ_ST:  reg_rdata <= irq_status;
                fps_pkg::ADDR_IRQ_EN:  reg_rdata <= irq_enable;
                default:               reg_rdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Current source drive
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive <= '0;
        end else if (shdn) begin
            drive <= '0;
        end else begin
            drive.en_a        <= src_a_on && state != fps_pkg::ST_OFF;
            drive.en_b        <= src_b_on && state != fps_pkg::ST_OFF;
            drive.indic_level <= (mode == fps_pkg::MODE_INDIC) ? indic_reg[2:0] : 3'h0;
            if (state == fps_pkg::ST_FLASH) begin
                drive.level_a <= flash_reg[3:0];
                drive.level_b <= flash_reg[7:4];
            end else begin
                drive.level_a <= {1'b0, torch_reg[2:0]};
                drive.level_b <= {1'b0, torch_reg[5:3]};
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flash_active  <= 1'b0;
            current_limit <= '0;
        end else begin
            flash_active  <= in_flash && !shdn;
            current_limit <= dur_reg[6:5];
        end
    end

endmodule : fps_top

// >>> include/fps_pkg.sv
package fps_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE  = 8'h00;
    localparam logic [7:0] ADDR_CONFIG1 = 8'h01;
    localparam logic [7:0] ADDR_TORCH   = 8'h02;
    localparam logic [7:0] ADDR_FLASH   = 8'h03;
    localparam logic [7:0] ADDR_DUR     = 8'h04;
    localparam logic [7:0] ADDR_FLAGS   = 8'h05;
    localparam logic [7:0] ADDR_ADC     = 8'h06;
    localparam logic [7:0] ADDR_INDIC   = 8'h07;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h09;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h0a;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          EN_MODE_LSB = 0;
    localparam int          EN_SRC_A    = 3;
    localparam int          EN_SRC_B    = 4;
    localparam int          CFG_POL_A   = 5;
    localparam int          CFG_POL_B   = 6;
    localparam int          CFG_PINFUNC = 7;
    localparam logic [7:0]  RST_ENABLE  = 8'h18;
    localparam logic [7:0]  RST_CONFIG1 = 8'h60;
    localparam logic [7:0]  RST_TORCH   = 8'h00;
    localparam logic [7:0]  RST_FLASH   = 8'h00;
    localparam logic [7:0]  RST_DUR     = 8'h0f;
    localparam logic [7:0]  RST_INDIC   = 8'h00;

    localparam logic [1:0]  MODE_OFF    = 2'h0;
    localparam logic [1:0]  MODE_INDIC  = 2'h1;
    localparam logic [1:0]  MODE_TORCH  = 2'h2;
    localparam logic [1:0]  MODE_FLASH  = 2'h3;

    // Flag bit positions
    localparam int FLG_TIMEOUT = 0;
    localparam int FLG_LED_OT  = 1;
    localparam int FLG_LED_FLT = 2;
    localparam int FLG_TSD     = 3;
    localparam int FLG_VIN_UV  = 4;
    localparam int FLG_VIN_FUV = 5;
    localparam int FLG_SYNC_A  = 6;
    localparam int FLG_SYNC_B  = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 125_000_000;
    localparam int SW_HZ       = 2_000_000;
    localparam int STEP_MS     = 32;
    localparam int SW_DIV      = CLK_HZ / SW_HZ;
    localparam int STEP_TICKS  = SW_HZ / 1000 * STEP_MS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF,
        ST_TORCH,
        ST_FLASH,
        ST_FORCED
    } fps_state_t;

    typedef struct packed {
        logic led_overtemp;
        logic led_fault;
        logic thermal_sd;
        logic vin_uv;
        logic vin_flash_uv;
    } fps_fault_t;

    typedef struct packed {
        logic       en_a;
        logic       en_b;
        logic [3:0] level_a;
        logic [3:0] level_b;
        logic [2:0] indic_level;
    } fps_drive_t;

endpackage : fps_pkg

// >>> src/fps_sync2.sv
`timescale 1ns/100ps
module fps_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : fps_sync2

// >>> src/fps_timer.sv
`timescale 1ns/100ps
module fps_timer #(
    parameter int DIV   = fps_pkg::SW_DIV,
    parameter int STEPS = fps_pkg::STEP_TICKS
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [4:0] code,
    output logic            expired
);
    // ------------------------------------------------------------
    // Switching clock divider, then 32 ms steps
    // ------------------------------------------------------------
    logic [7:0]  div_cnt;
    logic [19:0] tick_cnt;
    logic [4:0]  step_idx;
    logic        tick;
    logic        step_end;

    assign tick     = (div_cnt == 8'(DIV - 1));
    assign step_end = tick && (tick_cnt == 20'(STEPS - 1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (!run || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt <= '0;
            step_idx <= '0;
        end else if (!run) begin
            tick_cnt <= '0;
            step_idx <= '0;
        end else if (step_end) begin
            tick_cnt <= '0;
            step_idx <= step_idx + 5'h01;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 20'h00001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            expired <= 1'b0;
        end else begin
            expired <= run && step_end && (step_idx == code);
        end
    end
endmodule : fps_timer

// >>> tb/fps_pa_model.sv
`timescale 1ns/100ps
module fps_pa_model (
    input  wire logic clock,
    output logic      trigger,
    output logic      sync_a,
    output logic      sync_b,
    output logic      chip_en
);
    initial begin
        trigger = 1'b0;
        sync_a  = 1'b0;
        sync_b  = 1'b0;
        chip_en = 1'b1;
    end
    // ----------------------------------------
    // Pin stimulus, changed just after an edge
    // ----------------------------------------
    task automatic set_sync(input logic a, input logic b);
        @(posedge clock);
        sync_a <= a;
        sync_b <= b;
    endtask : set_sync
    task automatic strobe();
        @(posedge clock);
        trigger <= 1'b1;
        repeat (3) @(posedge clock);
        trigger <= 1'b0;
    endtask : strobe
    task automatic power(input logic on);
        @(posedge clock);
        chip_en <= on;
    endtask : power
endmodule : fps_pa_model

// >>> tb/fps_top_chk.sv
`timescale 1ns/100ps
module fps_top_chk #(
    parameter int STEP_TICKS = 4
) (
    input wire logic                clock,
    input wire logic                rst,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic                hw_chip_enable,
    input wire fps_pkg::fps_drive_t drive,
    input wire logic [1:0]          current_limit,
    input wire logic                flash_active,
    input wire logic                irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Length of the current flash
    // ----------------------------------------
    int ran;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ran <= 0;
        end else begin
            ran <= flash_active ? ran + 1 : 0;
        end
    end
    shut_off_a: assert property (!hw_chip_enable [*6] |-> drive == '0 && !flash_active)
        else $error("outputs active while disabled");
    active_drive_a: assert property (flash_active |-> drive.en_a || drive.en_b)
        else $error("flash without a source");
    unmapped_rd_a: assert property (reg_rd && reg_addr > 8'h0a |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    adc_width_a: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata[7:4] == 4'h0)
        else $error("converter result too wide");
    rdata_hold_a: assert property (!reg_rd && hw_chip_enable |=> $stable(reg_rdata))
        else $error("read data moved");
    run_max_a: assert property (ran <= 32 * STEP_TICKS * 62 + 8)
        else $error("flash outlived longest timeout");
    run_min_a: assert property ($fell(flash_active) && hw_chip_enable
        && $past(hw_chip_enable, 5) |-> $past(ran) >= STEP_TICKS * 62 - 2)
        else $error("flash ended before timeout");
    climit_copy_a: assert property (reg_wr && reg_addr == 8'h04 && hw_chip_enable
        && $past(hw_chip_enable, 4) |-> ##2 current_limit == $past(reg_wdata[6:5], 2))
        else $error("current limit not taken");
    irq_mask_a: assert property (reg_wr && reg_addr == 8'h0a && reg_wdata == 8'h00
        && hw_chip_enable |-> ##2 !irq)
        else $error("masked interrupt still high");
    flash_c: cover property ($rose(flash_active));
    end_c: cover property ($fell(flash_active));
    irq_c: cover property ($rose(irq));
endmodule : fps_top_chk
bind fps_top fps_top_chk #(.STEP_TICKS(STEP_TICKS)) chk (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hw_chip_enable(hw_chip_enable), .drive(drive), .current_limit(current_limit),
    .flash_active(flash_active), .irq(irq)
);

// >>> tb/tb_flash_pa_sync_control.sv
`timescale 1ns/100ps
module tb_flash_pa_sync_control;
    logic                clock = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          reg_addr = 8'h00;
    logic [7:0]          reg_wdata = 8'h00;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic                rd_q = 1'b0;
    logic [3:0]          vled_code = 4'h0;
    logic [7:0]          reg_rdata;
    logic                trig, pin_a, sync_b, hw_en;
    fps_pkg::fps_drive_t drive;
    logic [1:0]          current_limit;
    logic                flash_active, irq;
    logic [7:0]          tr, fl;
    fps_pkg::fps_fault_t fault = '0;
    logic [7:0]          exp_q[$];
    int                  error_cnt = 0;
    int                  checks = 0;
    always #4 clock = ~clock;
    fps_top #(.STEP_TICKS(4)) DUT (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_trigger_pin(trig), .multifunction_pin_a(pin_a), .pa_sync_in_b(sync_b),
        .hw_chip_enable(hw_en), .fault_pins(fault), .vled_code(vled_code), .drive(drive),
        .current_limit(current_limit), .flash_active(flash_active), .irq(irq)
    );
    fps_pa_model pa (
        .clock(clock), .trigger(trig), .sync_a(pin_a), .sync_b(sync_b), .chip_en(hw_en)
    );
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    function automatic logic [15:0] drv(input logic [3:0] a, input logic [3:0] b);
        return {1'b0, 2'b11, a, b, 3'h0};
    endfunction : drv
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask : hold
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic summarize();
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------
    // Read data monitor
    // ----------------------------------------
    always @(posedge clock) begin
        if (rd_q) begin
            check(16'(reg_rdata), 16'(exp_q.pop_front()));
        end
        rd_q <= reg_rd;
    end
    initial begin
        #200us;
        error_cnt++;
        summarize();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(74));
        tr = 8'($urandom) & 8'h3f;
        fl = 8'($urandom);
        vled_code <= 4'($urandom);
        hold(6);
        rst <= 1'b0;
        rd(fps_pkg::ADDR_ENABLE, fps_pkg::RST_ENABLE);
        rd(fps_pkg::ADDR_CONFIG1, fps_pkg::RST_CONFIG1);
        rd(fps_pkg::ADDR_DUR, fps_pkg::RST_DUR);
        rd(8'h3c, 8'h00);
        wr(fps_pkg::ADDR_TORCH, tr);
        wr(fps_pkg::ADDR_FLASH, fl);
        wr(fps_pkg::ADDR_DUR, 8'h40);
        wr(fps_pkg::ADDR_IRQ_EN, 8'hc1);
        wr(fps_pkg::ADDR_ENABLE, 8'h1b);
        hold(3);
        check(16'(drive), drv(fl[3:0], fl[7:4]));
        pa.set_sync(1'b1, 1'b0);
        hold(6);
        check(16'(drive), drv({1'b0, tr[2:0]}, {1'b0, tr[5:3]}));
        pa.set_sync(1'b0, 1'b0);
        hold(6);
        check(16'(drive), drv(fl[3:0], fl[7:4]));
        pa.set_sync(1'b1, 1'b0);
        for (int i = 0; i < 400 && flash_active !== 1'b0; i++) @(posedge clock);
        hold(2);
        check(16'(flash_active), 16'h0000);
        check(16'(drive), drv({1'b0, tr[2:0]}, {1'b0, tr[5:3]}) & 16'h07ff);
        check(16'(irq), 16'h0001);
        rd(fps_pkg::ADDR_FLAGS, 8'h41);
        rd(fps_pkg::ADDR_FLAGS, 8'h00);
        rd(fps_pkg::ADDR_ADC, {4'h0, vled_code});
        rd(fps_pkg::ADDR_ENABLE, 8'h18);
        wr(fps_pkg::ADDR_IRQ_CLR, 8'hff);
        hold(2);
        check(16'(irq), 16'h0000);
        wr(fps_pkg::ADDR_CONFIG1, 8'h00);
        pa.set_sync(1'b1, 1'b1);
        hold(4);
        pa.strobe();
        hold(6);
        check(16'(flash_active), 16'h0001);
        check(16'(drive), drv(fl[3:0], fl[7:4]));
        pa.set_sync(1'b1, 1'b0);
        hold(6);
        check(16'(drive), drv({1'b0, tr[2:0]}, {1'b0, tr[5:3]}));
        pa.power(1'b0);
        hold(7);
        check({flash_active, 15'(drive)}, 16'h0000);
        pa.power(1'b1);
        hold(4);
        rd(fps_pkg::ADDR_CONFIG1, fps_pkg::RST_CONFIG1);
        rd(fps_pkg::ADDR_IRQ_EN, 8'hc1);
        wr(fps_pkg::ADDR_TORCH, tr);
        wr(fps_pkg::ADDR_CONFIG1, 8'he0);
        pa.set_sync(1'b1, 1'b1);
        hold(6);
        check(16'(drive), drv({1'b0, tr[2:0]}, {1'b0, tr[5:3]}));
        pa.set_sync(1'b0, 1'b1);
        hold(6);
        check(16'(drive), drv({1'b0, tr[2:0]}, {1'b0, tr[5:3]}) & 16'h07ff);
        fault <= 5'h01;
        hold(3);
        rd(fps_pkg::ADDR_FLAGS, 8'h20);
        wr(fps_pkg::ADDR_IRQ_EN, 8'h00);
        hold(3);
        summarize();
    end
endmodule : tb_flash_pa_sync_control
